// File: gripper_regs_pkg.sv
// Purpose: shared constants and types of the gripper command/status bank
// Assumes: 100 MHz mclk
// Notes:   byte offsets index two 16-byte images
`default_nettype none
package gripper_regs_pkg;
	localparam int          IMG_BYTES = 16;
	localparam int          ADDR_W    = 4;
	// command image offsets
	localparam logic [3:0]  CMD_ACTION = 4'h0;
	localparam logic [3:0]  CMD_TARGET = 4'h3;
	localparam logic [3:0]  CMD_SPEED  = 4'h4;
	localparam logic [3:0]  CMD_FORCE  = 4'h5;
	// status image offsets
	localparam logic [3:0]  ST_SUMMARY = 4'h0;
	localparam logic [3:0]  ST_FAULT   = 4'h2;
	localparam logic [3:0]  ST_ECHO    = 4'h3;
	localparam logic [3:0]  ST_POS     = 4'h4;
	localparam logic [3:0]  ST_CURR    = 4'h5;
	// command_bits field positions
	localparam int          BIT_ACT  = 0;
	localparam int          BIT_MOVE = 3;
	localparam int          BIT_REL  = 4;
	localparam int          BIT_DIR  = 5;
	// power-up image: activation bit held set
	localparam logic [7:0]  CMD_ACTION_RST = 8'h01;
	localparam logic [7:0]  CMD_OTHER_RST  = 8'h00;
	// state_summary fields
	localparam int          SUM_STA_LSB = 4;
	localparam int          SUM_OBJ_LSB = 6;
	localparam logic [1:0]  STA_RESET   = 2'h0;
	localparam logic [1:0]  STA_ACTIVE  = 2'h1;
	localparam logic [1:0]  STA_DONE    = 2'h3;
	// fault codes
	localparam logic [7:0]  FLT_NONE     = 8'h00;
	localparam logic [7:0]  FLT_DELAYED  = 8'h05;
	localparam logic [7:0]  FLT_NOT_ACT  = 8'h07;
	localparam logic [7:0]  FLT_NO_COMM  = 8'h09;
	localparam logic [7:0]  FLT_MAJOR_LO = 8'h0A;
	localparam logic [7:0]  FLT_REL_BUSY = 8'h0B;
	localparam logic [7:0]  FLT_REL_DONE = 8'h0F;
	// communication silence limit
	localparam int unsigned CLK_KHZ         = 100000;
	localparam int unsigned COMM_TIMEOUT_MS = 1000;
	localparam int unsigned COMM_TIMEOUT_CYC = COMM_TIMEOUT_MS * CLK_KHZ;

	typedef enum logic [2:0] {
		GS_LOCKED     = 3'b000,
		GS_IDLE       = 3'b001,
		GS_ACTIVATING = 3'b010,
		GS_READY      = 3'b011,
		GS_RELEASING  = 3'b100,
		GS_RELEASED   = 3'b101
	} grip_state_t;
endpackage
`default_nettype wire

// File: comm_watchdog.sv
// Purpose: flags a silent link after a fixed number of cycles
// Assumes: activity is a one-cycle pulse on mclk
// Notes:   count saturates; any activity restarts it
`timescale 1ns/1ps
`default_nettype none
module comm_watchdog #(
	parameter int unsigned TIMEOUT_CYC = 100000000
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic activity,
	output logic      timed_out
);
	localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_CYC);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             to_r;
	logic             to_nxt;

	always_comb begin
		if (activity)
			cnt_nxt = '0;
		else if (cnt_r == LIMIT)
			cnt_nxt = cnt_r;
		else
			cnt_nxt = cnt_r + 1'b1;
		to_nxt = (cnt_nxt == LIMIT);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= '0;
			to_r  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			to_r  <= to_nxt;
		end
	end

	assign timed_out = to_r;

	a_silence_clears: assert property (@(posedge mclk) disable iff (rst)
		activity |=> !timed_out) else $error("timeout flag survived link activity");
endmodule // comm_watchdog
`default_nettype wire

// File: gripper_command_status_regs.sv
// Purpose: command and status byte images of the gripper controller
// Assumes: frame decoder and motor logic run on mclk
// Notes:   frame layer drives the byte write/read port
`timescale 1ns/1ps
`default_nettype none
module gripper_command_status_regs
	import gripper_regs_pkg::*;
#(
	parameter int unsigned COMM_TIMEOUT_CYCLES = COMM_TIMEOUT_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        rd_en,
	input  wire logic        rd_status,
	input  wire logic [3:0]  rd_addr,
	output logic      [7:0]  rd_data,
	output logic             rd_valid,
	input  wire logic        comm_activity,
	input  wire logic        act_routine_done,
	input  wire logic        release_at_limit,
	input  wire logic [7:0]  meas_position,
	input  wire logic [7:0]  meas_current,
	input  wire logic [1:0]  obj_state,
	output logic             activation_run,
	output logic             move_enable,
	output logic      [7:0]  target_position,
	output logic      [7:0]  speed_setting,
	output logic      [7:0]  force_limit_setting,
	output logic             release_run,
	output logic             release_direction,
	output logic      [7:0]  fault_code
);
	////////////////////////////////////////////////////////////////////////
	// command image
	logic [7:0]  cmd_r   [IMG_BYTES];
	logic [7:0]  cmd_nxt [IMG_BYTES];
	logic        act_prev_r;
	logic        act_prev_nxt;

	always_comb begin
		for (int i = 0; i < IMG_BYTES; i++) begin
			cmd_nxt[i] = cmd_r[i];
			if (wr_en && wr_addr == 4'(i))
				cmd_nxt[i] = wr_data;
		end
		act_prev_nxt = cmd_r[CMD_ACTION][BIT_ACT];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < IMG_BYTES; i++)
				cmd_r[i] <= (i == 0) ? CMD_ACTION_RST : CMD_OTHER_RST;
			act_prev_r <= 1'b1;
		end else begin
			for (int i = 0; i < IMG_BYTES; i++)
				cmd_r[i] <= cmd_nxt[i];
			act_prev_r <= act_prev_nxt;
		end
	end

	logic act_bit;
	logic move_bit;
	logic rel_bit;
	logic dir_bit;
	logic act_rise;

	assign act_bit  = cmd_r[CMD_ACTION][BIT_ACT];
	assign move_bit = cmd_r[CMD_ACTION][BIT_MOVE];
	assign rel_bit  = cmd_r[CMD_ACTION][BIT_REL];
	assign dir_bit  = cmd_r[CMD_ACTION][BIT_DIR];
	assign act_rise = act_bit && !act_prev_r;

	////////////////////////////////////////////////////////////////////////
	// link silence detection
	logic comm_timeout;

	comm_watchdog #(
		.TIMEOUT_CYC (COMM_TIMEOUT_CYCLES)
	) u_watchdog (
		.mclk      (mclk),
		.rst       (rst),
		.activity  (comm_activity),
		.timed_out (comm_timeout)
	);

	////////////////////////////////////////////////////////////////////////
	// gripper state and fault
	grip_state_t state_r;
	grip_state_t state_nxt;
	logic        rel_dir_r;
	logic        rel_dir_nxt;
	logic [7:0]  fault_r;
	logic [7:0]  fault_nxt;
	logic        major;
	logic        armed;

	assign major = (fault_r >= FLT_MAJOR_LO);
	assign armed = act_bit && (state_r != GS_LOCKED);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			GS_LOCKED: begin
				if (!act_bit)
					state_nxt = GS_IDLE;
			end
			GS_IDLE: begin
				if (act_bit)
					state_nxt = GS_ACTIVATING;
			end
			GS_ACTIVATING: begin
				if (!act_bit)
					state_nxt = GS_IDLE;
				else if (rel_bit)
					state_nxt = GS_RELEASING;
				else if (act_routine_done)
					state_nxt = GS_READY;
			end
			GS_READY: begin
				if (!act_bit)
					state_nxt = GS_IDLE;
				else if (rel_bit)
					state_nxt = GS_RELEASING;
			end
			GS_RELEASING: begin
				if (!act_bit)
					state_nxt = GS_IDLE;
				else if (release_at_limit)
					state_nxt = GS_RELEASED;
			end
			GS_RELEASED: begin
				if (!act_bit)
					state_nxt = GS_IDLE;
			end
			default: state_nxt = GS_IDLE;
		endcase

		rel_dir_nxt = rel_dir_r;
		if (state_r != GS_RELEASING && state_nxt == GS_RELEASING)
			rel_dir_nxt = dir_bit;

		fault_nxt = fault_r;
		if (act_rise)
			fault_nxt = FLT_NONE;
		if (state_nxt == GS_RELEASING)
			fault_nxt = FLT_REL_BUSY;
		else if (state_nxt == GS_RELEASED)
			fault_nxt = FLT_REL_DONE;
		else if (!major || act_rise) begin
			if (!armed)
				fault_nxt = (move_bit || rel_bit) ? FLT_NOT_ACT : FLT_NONE;
			else if (state_r == GS_ACTIVATING && move_bit)
				fault_nxt = FLT_DELAYED;
			else if (comm_timeout)
				fault_nxt = FLT_NO_COMM;
			else
				fault_nxt = FLT_NONE;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r   <= GS_LOCKED;
			rel_dir_r <= 1'b0;
			fault_r   <= FLT_NONE;
		end else begin
			state_r   <= state_nxt;
			rel_dir_r <= rel_dir_nxt;
			fault_r   <= fault_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// motion control outputs
	assign activation_run      = (state_r == GS_ACTIVATING);
	assign move_enable         = (state_r == GS_READY) && move_bit && !rel_bit;
	assign release_run         = (state_r == GS_RELEASING);
	assign release_direction   = rel_dir_r;
	assign target_position     = cmd_r[CMD_TARGET];
	assign speed_setting       = cmd_r[CMD_SPEED];
	assign force_limit_setting = cmd_r[CMD_FORCE];
	assign fault_code          = fault_r;

	////////////////////////////////////////////////////////////////////////
	// status image and read port
	function automatic logic [1:0] sta_code(input grip_state_t s);
		case (s)
			GS_ACTIVATING: sta_code = STA_ACTIVE;
			GS_READY:      sta_code = STA_DONE;
			default:       sta_code = STA_RESET;
		endcase
	endfunction

	logic [7:0] stat_img [IMG_BYTES];
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic       rd_valid_r;

	always_comb begin
		for (int i = 0; i < IMG_BYTES; i++)
			stat_img[i] = 8'h00;
		stat_img[ST_SUMMARY][BIT_ACT]  = act_bit;
		stat_img[ST_SUMMARY][BIT_MOVE] = move_bit;
		stat_img[ST_SUMMARY][SUM_STA_LSB +: 2] = sta_code(state_r);
		stat_img[ST_SUMMARY][SUM_OBJ_LSB +: 2] = obj_state;
		stat_img[ST_FAULT] = fault_r;
		stat_img[ST_ECHO]  = cmd_r[CMD_TARGET];
		stat_img[ST_POS]   = meas_position;
		stat_img[ST_CURR]  = meas_current;
		rd_data_nxt = rd_data_r;
		if (rd_en)
			rd_data_nxt = rd_status ? stat_img[rd_addr] : cmd_r[rd_addr];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_data_r  <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r  <= rd_data_nxt;
			rd_valid_r <= rd_en;
		end
	end

	assign rd_data  = rd_data_r;
	assign rd_valid = rd_valid_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_move_needs_ready: assert property (move_enable |-> state_r == GS_READY && act_bit)
		else $error("motion enabled outside ready state");
	a_release_wins: assert property (rel_bit |-> !move_enable)
		else $error("move enabled while auto-release set");
	a_deact_resets: assert property (!act_bit && state_r != GS_LOCKED |=> state_r == GS_IDLE)
		else $error("clearing activation did not reset");
	a_power_lock: assert property (@(posedge mclk) disable iff (1'b0)
		rst |=> state_r == GS_LOCKED && act_bit)
		else $error("power-up image not locked");
	a_not_act_fault: assert property ((!armed && (move_bit || rel_bit) && !major) |=> fault_r == FLT_NOT_ACT)
		else $error("missing not-activated fault");
	// routine finishing in the same cycle lets the delayed move start at once
	a_delay_fault: assert property (
		(state_r == GS_ACTIVATING && act_bit && move_bit && !rel_bit && !major && !act_routine_done)
		|=> fault_r == FLT_DELAYED ##0 !move_enable)
		else $error("missing action-delayed fault");
	a_major_sticky: assert property ((major && !act_rise) |=> major)
		else $error("major fault cleared without activation edge");
	a_release_done: assert property (
		(state_r == GS_RELEASING && release_at_limit && act_bit)
		|=> fault_r == FLT_REL_DONE ##1 (!move_enable) [*2])
		else $error("auto-release completion not faulted");
	a_dir_held: assert property (
		(state_r == GS_RELEASING && $past(state_r) == GS_RELEASING)
		|-> $stable(release_direction))
		else $error("release direction changed mid release");
	a_speed_no_start: assert property (
		(!move_enable && state_r == GS_READY && wr_en && wr_addr == CMD_SPEED)
		|=> !move_enable)
		else $error("speed write started motion");
	a_silence_fault: assert property (
		(state_r == GS_READY && act_bit && !rel_bit && !major && comm_timeout)
		|=> fault_r == FLT_NO_COMM)
		else $error("silent link not reported");
	a_status_read: assert property (
		(rd_en && rd_status && rd_addr == ST_FAULT) |=> rd_valid && rd_data == $past(fault_r))
		else $error("fault byte read mismatch");

	c_activation_done: cover property (state_r == GS_ACTIVATING ##1 state_r == GS_READY);
	c_move: cover property (state_r == GS_READY && move_enable);
	c_release_done: cover property (state_r == GS_RELEASING ##1 state_r == GS_RELEASED);
	c_no_comm: cover property (fault_r == FLT_NO_COMM);
	c_delayed_move: cover property (state_r == GS_ACTIVATING && move_bit ##1 move_enable);
endmodule // gripper_command_status_regs
`default_nettype wire

// File: ctrl_master.sv
// Purpose: robot controller model driving the byte image port of the gripper bank
// Assumes: requests change at falling mclk and are taken at the next rising edge
// Notes:   every access counts as a received frame; released lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module ctrl_master (
	input  wire logic       mclk,
	output logic            wr_en,
	output logic      [3:0] wr_addr,
	output logic      [7:0] wr_data,
	output logic            rd_en,
	output logic            rd_status,
	output logic      [3:0] rd_addr,
	output logic            comm_activity,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 4'h0;
		wr_data = 8'h00;
		rd_en = 1'b0;
		rd_status = 1'b0;
		rd_addr = 4'h0;
		comm_activity = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// functions reached only by writing the command image
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		comm_activity = 1'b1;
		@(negedge mclk);
		wr_en = 1'b0;
		comm_activity = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
	endtask
	// condition obtained only by reading an image; answer read half a cycle after the take
	task automatic get(input logic st, input logic [3:0] a, output logic [7:0] d, output logic v);
		@(negedge mclk);
		rd_en = 1'b1;
		rd_status = st;
		rd_addr = a;
		comm_activity = 1'b1;
		@(negedge mclk);
		rd_en = 1'b0;
		comm_activity = 1'b0;
		rd_addr = ~a;
		rd_status = ~st;
		v = rd_valid;
		d = rd_data;
	endtask
endmodule // ctrl_master
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench of the gripper command and status bank
// Assumes: short silence limit; motor side driven by the bench
// Notes:   outputs are sampled at falling mclk, three cycles after each write
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gripper_regs_pkg::*;
	localparam int unsigned TO = 50;
	logic       mclk, rst, wr_en, rd_en, rd_status, rd_valid, comm_activity;
	logic [3:0] wr_addr, rd_addr;
	logic [7:0] wr_data, rd_data, meas_position, meas_current, d;
	logic       act_routine_done, release_at_limit, v;
	logic [1:0] obj_state;
	logic       activation_run, move_enable, release_run, release_direction;
	logic [7:0] target_position, speed_setting, force_limit_setting, fault_code;
	int         failures, check_count;
	gripper_command_status_regs #(.COMM_TIMEOUT_CYCLES(TO)) uut (.mclk(mclk), .rst(rst), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_status(rd_status), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_valid(rd_valid), .comm_activity(comm_activity), .act_routine_done(act_routine_done),
		.release_at_limit(release_at_limit), .meas_position(meas_position), .meas_current(meas_current),
		.obj_state(obj_state), .activation_run(activation_run), .move_enable(move_enable),
		.target_position(target_position), .speed_setting(speed_setting), .force_limit_setting(force_limit_setting),
		.release_run(release_run), .release_direction(release_direction), .fault_code(fault_code));
	ctrl_master ctl (.mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
		.rd_status(rd_status), .rd_addr(rd_addr), .comm_activity(comm_activity), .rd_data(rd_data), .rd_valid(rd_valid));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] b(input logic x);
		return {7'h00, x};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		ctl.put(a, x);
		cyc(3);
	endtask
	task automatic rs(input logic st, input logic [3:0] a, input logic [7:0] e, input string n);
		ctl.get(st, a, d, v);
		chk("read valid", 8'h01, b(v));
		chk(n, e, d);
	endtask
	task automatic pulse_done();
		act_routine_done = 1'b1;
		cyc(1);
		act_routine_done = 1'b0;
		cyc(3);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("fault", FLT_NONE, fault_code);
		chk("motion", 8'h00, {5'h00, activation_run, move_enable, release_run});
		rs(1'b0, CMD_ACTION, CMD_ACTION_RST, "act readback");
		wr(CMD_ACTION, 8'h09);
		chk("locked motion", 8'h00, {6'h00, activation_run, move_enable});
		chk("fault", FLT_NOT_ACT, fault_code);
	endtask
	task automatic t_activate();
		wr(CMD_ACTION, 8'h00);
		chk("fault", FLT_NONE, fault_code);
		wr(CMD_ACTION, 8'h01);
		chk("act run", 8'h01, b(activation_run));
		rs(1'b1, ST_SUMMARY, {2'h2, STA_ACTIVE, 4'h1}, "summary");
		wr(CMD_ACTION, 8'h09);
		chk("fault", FLT_DELAYED, fault_code);
		chk("move", 8'h00, b(move_enable));
		pulse_done();
		chk("move", 8'h01, b(move_enable));
		rs(1'b1, ST_SUMMARY, {2'h2, STA_DONE, 4'h9}, "summary");
		wr(CMD_ACTION, 8'h01);
		chk("move", 8'h00, b(move_enable));
	endtask
	task automatic t_bytes();
		wr(CMD_TARGET, 8'hFF);
		wr(CMD_SPEED, 8'h80);
		wr(CMD_FORCE, 8'h00);
		wr(4'h6, 8'hAA);
		chk("target", 8'hFF, target_position);
		chk("speed", 8'h80, speed_setting);
		chk("force", 8'h00, force_limit_setting);
		chk("move", 8'h00, b(move_enable));
		rs(1'b1, ST_ECHO, 8'hFF, "echo");
		rs(1'b1, ST_POS, 8'h5A, "position");
		rs(1'b1, ST_CURR, 8'hC3, "current");
		rs(1'b1, ST_FAULT, FLT_NONE, "fault byte");
		rs(1'b1, 4'h6, 8'h00, "status spare");
		rs(1'b0, 4'h6, 8'hAA, "command spare");
		wr(4'h6, 8'h00);
		rs(1'b0, 4'h6, 8'h00, "command spare");
		wr(CMD_ACTION, 8'hC9);
		chk("move", 8'h01, b(move_enable));
		obj_state = 2'h1;
		rs(1'b1, ST_SUMMARY, {2'h1, STA_DONE, 4'h9}, "summary");
		wr(CMD_SPEED, 8'hFF);
		chk("speed", 8'hFF, speed_setting);
		wr(CMD_FORCE, 8'hFF);
		chk("force", 8'hFF, force_limit_setting);
		wr(CMD_TARGET, 8'h00);
		chk("target", 8'h00, target_position);
		chk("move", 8'h01, b(move_enable));
		wr(CMD_ACTION, 8'h01);
	endtask
	task automatic t_silence();
		cyc(TO - 8);
		chk("fault", FLT_NONE, fault_code);
		cyc(12);
		chk("fault", FLT_NO_COMM, fault_code);
		rs(1'b1, ST_FAULT, FLT_NO_COMM, "fault byte");
		cyc(3);
		chk("fault", FLT_NONE, fault_code);
	endtask
	task automatic t_release();
		for (int i = 0; i < 2; i++) begin
			wr(CMD_ACTION, 8'h00);
			wr(CMD_ACTION, 8'h01);
			pulse_done();
			wr(CMD_ACTION, {2'b00, i[0], 5'h19});
			chk("release run", 8'h01, b(release_run));
			chk("move", 8'h00, b(move_enable));
			chk("direction", b(i[0]), b(release_direction));
			chk("fault", FLT_REL_BUSY, fault_code);
			wr(CMD_ACTION, {2'b00, ~i[0], 5'h19});
			chk("direction", b(i[0]), b(release_direction));
			release_at_limit = 1'b1;
			cyc(3);
			release_at_limit = 1'b0;
			chk("fault", FLT_REL_DONE, fault_code);
			wr(CMD_ACTION, 8'h09);
			chk("move", 8'h00, b(move_enable));
			wr(CMD_ACTION, 8'h00);
			chk("fault", FLT_REL_DONE, fault_code);
			wr(CMD_ACTION, 8'h01);
			chk("fault", FLT_NONE, fault_code);
			chk("act run", 8'h01, b(activation_run));
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		act_routine_done = 1'b0;
		release_at_limit = 1'b0;
		meas_position = 8'h5A;
		meas_current = 8'hC3;
		obj_state = 2'h2;
		failures = 0;
		check_count = 0;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		cyc(1);
		t_reset();
		t_activate();
		t_bytes();
		t_silence();
		t_release();
		give_verdict();
	end
	// hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
